// ---- include/bsw_pkg.sv ----
// Package for the secondary status and memory window configuration block
package bsw_pkg;
  // ---------------------------------------------------------------
  // Configuration dword offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] BSW_OFF_SEC_STATUS = 8'h1C;
  localparam logic [7:0] BSW_OFF_MEM_WINDOW = 8'h20;
  // ---------------------------------------------------------------
  // Secondary status field positions
  // ---------------------------------------------------------------
  localparam int BSW_BIT_HIGH_SPEED = 21;
  localparam int BSW_BIT_FAST_B2B = 23;
  localparam int BSW_BIT_DATA_PAR = 24;
  localparam int BSW_BIT_SPEED_LO = 25;
  localparam int BSW_BIT_SIG_TABORT = 27;
  localparam int BSW_BIT_RCV_TABORT = 28;
  localparam int BSW_BIT_RCV_MABORT = 29;
  localparam int BSW_BIT_RCV_SERR = 30;
  localparam int BSW_BIT_DET_PERR = 31;
  // ---------------------------------------------------------------
  // Constant fields and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] BSW_SELECT_RESPONSE_SPEED = 2'h1;
  localparam logic BSW_FAST_B2B_VAL = 1'b1;
  localparam logic [4:0] BSW_FLAGS_RESET = 5'h00;
  localparam logic [11:0] BSW_WINDOW_RESET = 12'h000;
  localparam logic [19:0] BSW_LIMIT_LOW_FILL = 20'hFFFFF;
  localparam logic [19:0] BSW_BASE_LOW_FILL = 20'h00000;
  // Field position of base [15:4] and limit [31:20] inside dword 0x20
  localparam int BSW_BASE_LSB = 4;
  localparam int BSW_LIMIT_LSB = 20;
endpackage

// ---- rtl/bsw_regs.sv ----
// Secondary status half-word and non-prefetchable memory window registers
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Contract
// - Writing one clears a status flag; writing zero leaves it alone.
// - Status bits 20:16 and 22 always read zero.
// - Status bit 21 follows the high-speed strap level.
// - Status bit 23 always reads one.
// - Bit 24 sets on secondary mastering parity error with response enable.
// - Status bits 26:25 read constant 01b.
// - Bit 27 sets when device signals target abort as secondary target.
// - Bit 28 sets when device as secondary master receives target abort.
// - Bit 29 sets when device-initiated secondary transaction master aborts.
// - Bit 30 sets when secondary system-error line is seen asserted.
// - Bit 31 sets on secondary address or data parity error, always.
// - Base bits 3:0 and limit bits 19:16 read zero.
// - Base bits 15:4 give window lower bound address bits 31:20.
// - Limit bits 31:20 give upper bound bits 31:20, low bits ones.
// - Base and limit decide memory forwarding at 1 MB granularity.
// - Status lives in upper half of dword 0x1C, upper byte enables.
// - Base lower half, limit upper half of dword 0x20, own enables.
// ---------------------------------------------------------------
module bsw_regs
  import bsw_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Configuration access, byte enables active low
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_primary_command_byte_enables_n,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_hit,
  // Strap and bridge control
  input wire logic i_high_speed_strap,
  input wire logic i_parity_response_en,
  // Secondary bus events, one-cycle pulses
  input wire logic i_sec_master_active,
  input wire logic i_secondary_parity_error_line_n,
  input wire logic i_primary_parity_error,
  input wire logic i_sec_target_abort_sent,
  input wire logic i_sec_target_abort_rcvd,
  input wire logic i_sec_master_abort_rcvd,
  input wire logic i_secondary_system_error_line_n,
  input wire logic i_sec_parity_error,
  // Forwarding decision
  input wire logic [ADDR_W-1:0] i_fwd_addr,
  output logic o_fwd_in_window,
  output logic [ADDR_W-1:0] o_window_lo,
  output logic [ADDR_W-1:0] o_window_hi
);

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  function automatic logic lane_pair(input logic [3:0] be_n, input logic upper);
    lane_pair = upper ? (be_n[3:2] != 2'h3) : (be_n[1:0] != 2'h3);
  endfunction

  // Write one to clear: keep the bit unless a one is written
  function automatic logic [4:0] w1c(input logic [4:0] cur, input logic [4:0] wr);
    w1c = cur & ~wr;
  endfunction

  logic wr_status;
  logic wr_base;
  logic wr_limit;
  logic [4:0] err_flags;
  logic [11:0] mem_base;
  logic [11:0] mem_limit;
  logic strap_q;
  logic [4:0] next_err_flags;
  logic [4:0] set_ev;
  logic [4:0] clr_mask;
  logic [15:0] status_hw;
  logic [ADDR_W-1:0] lo_addr;
  logic [ADDR_W-1:0] hi_addr;

  assign wr_status = i_cfg_wr && (i_cfg_addr == BSW_OFF_SEC_STATUS)
                     && lane_pair(i_primary_command_byte_enables_n, 1'b1);
  assign wr_base = i_cfg_wr && (i_cfg_addr == BSW_OFF_MEM_WINDOW)
                   && lane_pair(i_primary_command_byte_enables_n, 1'b0);
  assign wr_limit = i_cfg_wr && (i_cfg_addr == BSW_OFF_MEM_WINDOW)
                    && lane_pair(i_primary_command_byte_enables_n, 1'b1);

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_comb begin
    // data parity gated by mastering and response enable
    set_ev[0] = i_sec_master_active && i_parity_response_en
                && (!i_secondary_parity_error_line_n || i_primary_parity_error);
    set_ev[1] = i_sec_target_abort_sent;
    set_ev[2] = i_sec_target_abort_rcvd;
    set_ev[3] = i_sec_master_abort_rcvd;
    set_ev[4] = !i_secondary_system_error_line_n;
    // Byte 3 lane holds bits 31:24; only its enable clears flags
    clr_mask = '0;
    if (wr_status && !i_primary_command_byte_enables_n[3]) begin
      clr_mask = {i_cfg_wdata[BSW_BIT_RCV_SERR], i_cfg_wdata[BSW_BIT_RCV_MABORT],
                  i_cfg_wdata[BSW_BIT_RCV_TABORT], i_cfg_wdata[BSW_BIT_SIG_TABORT],
                  i_cfg_wdata[BSW_BIT_DATA_PAR]};
    end
    // clear by one, a same-cycle event wins over the clear
    next_err_flags = w1c(err_flags, clr_mask) | set_ev;
  end

  logic det_perr;
  logic next_det_perr;
  always_comb begin
    next_det_perr = det_perr;
    // write one clears detected parity error
    if (wr_status && !i_primary_command_byte_enables_n[3] && i_cfg_wdata[BSW_BIT_DET_PERR]) begin
      next_det_perr = 1'b0;
    end
    if (i_sec_parity_error) begin
      next_det_perr = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      err_flags <= BSW_FLAGS_RESET;
      det_perr <= 1'b0;
    end else begin
      err_flags <= next_err_flags;
      det_perr <= next_det_perr;
    end
  end

  // Strap has no defined reset value; it is sampled every clock
  // strap level tracked
  always_ff @(posedge i_clk) begin
    strap_q <= i_high_speed_strap;
  end

  // ---------------------------------------------------------------
  // Memory window fields
  // ---------------------------------------------------------------
  // window fields clear on reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_base <= BSW_WINDOW_RESET;
      mem_limit <= BSW_WINDOW_RESET;
    end else begin
      // base field writable, byte lanes honoured
      if (wr_base) begin
        if (!i_primary_command_byte_enables_n[0]) begin
          mem_base[3:0] <= i_cfg_wdata[BSW_BASE_LSB +: 4];
        end
        if (!i_primary_command_byte_enables_n[1]) begin
          mem_base[11:4] <= i_cfg_wdata[BSW_BASE_LSB + 4 +: 8];
        end
      end
      // limit field writable, byte lanes honoured
      if (wr_limit) begin
        if (!i_primary_command_byte_enables_n[2]) begin
          mem_limit[3:0] <= i_cfg_wdata[BSW_LIMIT_LSB +: 4];
        end
        if (!i_primary_command_byte_enables_n[3]) begin
          mem_limit[11:4] <= i_cfg_wdata[BSW_LIMIT_LSB + 4 +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    // reserved bits stay zero by default
    status_hw = '0;
    status_hw[BSW_BIT_HIGH_SPEED - 16] = strap_q;
    status_hw[BSW_BIT_FAST_B2B - 16] = BSW_FAST_B2B_VAL;
    status_hw[BSW_BIT_SPEED_LO - 16 +: 2] = BSW_SELECT_RESPONSE_SPEED;
    status_hw[BSW_BIT_DATA_PAR - 16] = err_flags[0];
    status_hw[BSW_BIT_SIG_TABORT - 16] = err_flags[1];
    status_hw[BSW_BIT_RCV_TABORT - 16] = err_flags[2];
    status_hw[BSW_BIT_RCV_MABORT - 16] = err_flags[3];
    status_hw[BSW_BIT_RCV_SERR - 16] = err_flags[4];
    status_hw[BSW_BIT_DET_PERR - 16] = det_perr;
  end

  // Lower half of 0x1C belongs to the I/O window block and reads zero here
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cfg_rdata <= '0;
      o_cfg_hit <= 1'b0;
    end else begin
      o_cfg_hit <= i_cfg_rd && ((i_cfg_addr == BSW_OFF_SEC_STATUS)
                                || (i_cfg_addr == BSW_OFF_MEM_WINDOW));
      if (i_cfg_rd && (i_cfg_addr == BSW_OFF_SEC_STATUS)) begin
        o_cfg_rdata <= {status_hw, 16'h0000};
      end else if (i_cfg_rd && (i_cfg_addr == BSW_OFF_MEM_WINDOW)) begin
        o_cfg_rdata <= {mem_limit, 4'h0, mem_base, 4'h0};
      end else begin
        o_cfg_rdata <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Forwarding window
  // ---------------------------------------------------------------
  // lower bound, low bits zero
  assign lo_addr = ADDR_W'({mem_base, BSW_BASE_LOW_FILL});
  assign hi_addr = ADDR_W'({mem_limit, BSW_LIMIT_LOW_FILL});

  // Registered decision: one cycle from address to answer.
  // Until software programs the window (base 0, limit 0) the first 1 MB matches.
  // window decides forwarding
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fwd_in_window <= 1'b0;
      o_window_lo <= '0;
      o_window_hi <= '0;
    end else begin
      o_fwd_in_window <= (i_fwd_addr >= lo_addr) && (i_fwd_addr <= hi_addr);
      o_window_lo <= lo_addr;
      o_window_hi <= hi_addr;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_serr_seen;
    !i_secondary_system_error_line_n;
  endsequence

  a_w1c_clears: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_status && !i_primary_command_byte_enables_n[3] && i_cfg_wdata[BSW_BIT_RCV_TABORT]
     && !i_sec_target_abort_rcvd) |=> !err_flags[2])
    else $error("target abort flag not cleared");
  a_zero_keeps: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_status && !i_cfg_wdata[BSW_BIT_DET_PERR] && det_perr) |=> det_perr)
    else $error("zero write changed flag");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_cfg_hit) && $past(i_cfg_addr) == BSW_OFF_SEC_STATUS |->
    o_cfg_rdata[20:16] == 5'h00 && !o_cfg_rdata[22] && o_cfg_rdata[23]
    && o_cfg_rdata[26:25] == 2'h1)
    else $error("status constants wrong");
  a_parity_gate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!err_flags[0] && !i_parity_response_en) |=> !err_flags[0])
    else $error("data parity set without enable");
  a_serr_sets: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    s_serr_seen |=> err_flags[4] [*1])
    else $error("system error flag not set");
  a_perr_sets: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_sec_parity_error |=> det_perr)
    else $error("detected parity not set");
  a_mabort_sets: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_sec_master_abort_rcvd |=> err_flags[3])
    else $error("master abort flag not set");
  a_mem_low_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == BSW_OFF_MEM_WINDOW) |=>
    o_cfg_rdata[3:0] == 4'h0 && o_cfg_rdata[19:16] == 4'h0
    && o_cfg_rdata[31:20] == $past(mem_limit))
    else $error("window read wrong");
  a_window_match: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_fwd_in_window |-> ($past(i_fwd_addr) >= o_window_lo) && ($past(i_fwd_addr) <= o_window_hi))
    else $error("address outside window matched");
  // Flags, lanes, refused accesses and reset state
  a_det_clears: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_status && !i_primary_command_byte_enables_n[3] && i_cfg_wdata[BSW_BIT_DET_PERR]
     && !i_sec_parity_error) |=> !det_perr)
    else $error("detected parity not cleared");
  a_tabort_sent: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_sec_target_abort_sent |=> err_flags[1])
    else $error("signaled target abort flag not set");
  a_tabort_rcvd: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_sec_target_abort_rcvd |=> err_flags[2])
    else $error("received target abort flag not set");
  a_parity_sets: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_sec_master_active && i_parity_response_en
     && (!i_secondary_parity_error_line_n || i_primary_parity_error)) |=> err_flags[0])
    else $error("data parity flag not set");
  a_parity_master: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!err_flags[0] && !i_sec_master_active) |=> !err_flags[0])
    else $error("data parity set without mastership");
  a_strap_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_cfg_hit && $past(i_cfg_addr) == BSW_OFF_SEC_STATUS) |->
    o_cfg_rdata[BSW_BIT_HIGH_SPEED] == $past(i_high_speed_strap, 2))
    else $error("strap bit does not follow pin");
  a_status_low_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_cfg_hit && $past(i_cfg_addr) == BSW_OFF_SEC_STATUS) |-> o_cfg_rdata[15:0] == 16'h0000)
    else $error("status read lower half not zero");
  a_hit_status: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == BSW_OFF_SEC_STATUS) |=> o_cfg_hit)
    else $error("status read not claimed");
  a_hit_window: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == BSW_OFF_MEM_WINDOW) |=> o_cfg_hit)
    else $error("window read not claimed");
  a_refused_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr != BSW_OFF_SEC_STATUS && i_cfg_addr != BSW_OFF_MEM_WINDOW) |=>
    !o_cfg_hit && o_cfg_rdata == '0)
    else $error("foreign read answered");
  a_other_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_cfg_wr && i_cfg_addr != BSW_OFF_MEM_WINDOW) |=>
    $stable(mem_base) && $stable(mem_limit))
    else $error("foreign write moved window");
  a_base_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_base && i_primary_command_byte_enables_n[1:0] == 2'h0) |=>
    {16'h0000, mem_base, 4'h0} == ($past(i_cfg_wdata) & 32'h0000FFF0))
    else $error("base field write lost");
  a_limit_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_limit && i_primary_command_byte_enables_n[3:2] == 2'h0) |=>
    {mem_limit, 20'h00000} == ($past(i_cfg_wdata) & 32'hFFF00000))
    else $error("limit field write lost");
  a_base_keep: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_limit && !wr_base) |=> $stable(mem_base))
    else $error("limit write moved base");
  a_limit_keep: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_base && !wr_limit) |=> $stable(mem_limit))
    else $error("base write moved limit");
  a_window_fill: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $past(i_arst_n) |-> o_window_hi[19:0] == BSW_LIMIT_LOW_FILL
    && o_window_lo[19:0] == BSW_BASE_LOW_FILL)
    else $error("window low bits wrong");
  a_fwd_inside: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ($past(i_arst_n) && $past(i_fwd_addr) >= o_window_lo && $past(i_fwd_addr) <= o_window_hi)
    |-> o_fwd_in_window)
    else $error("address inside window missed");
  a_reset_clears: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !$past(i_arst_n) |-> err_flags == BSW_FLAGS_RESET && !det_perr
    && mem_base == BSW_WINDOW_RESET && mem_limit == BSW_WINDOW_RESET)
    else $error("state not cleared by reset");
endmodule

// ---- sim/bsw_sec_agent.sv ----
// Secondary bus agent model raising one event pulse per request
`timescale 1ns/1ps
module bsw_sec_agent (
  // Clock and request from the bench
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [2:0] i_kind,
  // Event lines toward the bridge
  output logic o_tabort_sent,
  output logic o_tabort_rcvd,
  output logic o_mabort_rcvd,
  output logic o_serr_line_n,
  output logic o_sec_perr,
  output logic o_perr_line_n,
  output logic o_pri_perr
);
  // Pulled-up lines rest high between events
  // one-cycle events
  always @(posedge i_clk) begin
    o_tabort_sent <= i_go && (i_kind == 3'h0);
    o_tabort_rcvd <= i_go && (i_kind == 3'h1);
    o_mabort_rcvd <= i_go && (i_kind == 3'h2);
    o_serr_line_n <= !(i_go && (i_kind == 3'h3));
    o_sec_perr <= i_go && (i_kind == 3'h4);
    o_perr_line_n <= !(i_go && (i_kind == 3'h5));
    o_pri_perr <= i_go && (i_kind == 3'h6);
  end
endmodule

// ---- sim/tb_bsw_regs.sv ----
// Self-checking bench for the secondary status and memory window block
`timescale 1ns/1ps
module tb_bsw_regs;
  import bsw_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic i_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic strap = 1'b1;
  logic pre = 1'b0;
  logic mst = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be_n = 4'hF;
  logic [31:0] wdata = 32'h0;
  logic [31:0] faddr = 32'h0;
  logic [31:0] rdata, lo, hi;
  logic hit, inwin, tas, tar, mar, serr_n, sperr, perr_n, pperr;
  int mismatches = 0;
  int cmp_count = 0;
  // Strap high: bits 21, 23 and 26:25 = 01b
  localparam logic [31:0] ST_BASE = 32'h02A00000;
  bsw_sec_agent agent (.i_clk(i_clk), .i_go(go), .i_kind(kind), .o_tabort_sent(tas),
    .o_tabort_rcvd(tar), .o_mabort_rcvd(mar), .o_serr_line_n(serr_n), .o_sec_perr(sperr),
    .o_perr_line_n(perr_n), .o_pri_perr(pperr));
  bsw_regs dut (.i_clk(i_clk), .i_arst_n(arst_n), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_addr(addr), .i_primary_command_byte_enables_n(be_n), .i_cfg_wdata(wdata),
    .o_cfg_rdata(rdata), .o_cfg_hit(hit), .i_high_speed_strap(strap),
    .i_parity_response_en(pre), .i_sec_master_active(mst),
    .i_secondary_parity_error_line_n(perr_n), .i_primary_parity_error(pperr),
    .i_sec_target_abort_sent(tas), .i_sec_target_abort_rcvd(tar),
    .i_sec_master_abort_rcvd(mar), .i_secondary_system_error_line_n(serr_n),
    .i_sec_parity_error(sperr), .i_fwd_addr(faddr), .o_fwd_in_window(inwin),
    .o_window_lo(lo), .o_window_hi(hi));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    addr <= a;
    be_n <= be;
    wdata <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_hit);
    @(posedge i_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    check({31'h0, hit}, {31'h0, exp_hit});
  endtask
  task automatic fire(input logic [2:0] k, input logic en, input logic m);
    @(posedge i_clk);
    pre <= en;
    mst <= m;
    kind <= k;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic fwd(input logic [31:0] a, input logic exp);
    @(posedge i_clk);
    faddr <= a;
    @(posedge i_clk);
    #1;
    check({31'h0, inwin}, {31'h0, exp});
  endtask
  function automatic int flag_bit(input int k);
    case (k)
      0: return BSW_BIT_SIG_TABORT;
      1: return BSW_BIT_RCV_TABORT;
      2: return BSW_BIT_RCV_MABORT;
      3: return BSW_BIT_RCV_SERR;
      4: return BSW_BIT_DET_PERR;
      default: return BSW_BIT_DATA_PAR;
    endcase
  endfunction
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd_chk(8'h1C, ST_BASE, 1'b1);
    rd_chk(8'h20, 32'h0, 1'b1);
    check(lo, 32'h0);
    check(hi, 32'h000FFFFF);
    @(posedge i_clk);
    strap <= 1'b0;
    rd_chk(8'h1C, 32'h02800000, 1'b1);
    @(posedge i_clk);
    strap <= 1'b1;
  endtask
  task automatic t_flags;
    logic [31:0] v;
    for (int k = 0; k < 7; k++) begin
      fire(k[2:0], k >= 5, k >= 5);
      v = ST_BASE | (32'h1 << flag_bit(k));
      rd_chk(8'h1C, v, 1'b1);
      cfg_wr(8'h1C, 4'h0, 32'h0);
      rd_chk(8'h1C, v, 1'b1);
      cfg_wr(8'h1C, 4'h3, 32'hFFFFFFFF);
      rd_chk(8'h1C, ST_BASE, 1'b1);
    end
    // Parity flag needs both enable and mastership
    fire(3'h5, 1'b0, 1'b1);
    rd_chk(8'h1C, ST_BASE, 1'b1);
    fire(3'h6, 1'b1, 1'b0);
    rd_chk(8'h1C, ST_BASE, 1'b1);
  endtask
  task automatic t_window;
    cfg_wr(8'h20, 4'h0, 32'h00F00010);
    rd_chk(8'h20, 32'h00F00010, 1'b1);
    check(lo, 32'h00100000);
    check(hi, 32'h00FFFFFF);
    fwd(32'h000FFFFF, 1'b0);
    fwd(32'h00100000, 1'b1);
    fwd(32'h00FFFFFF, 1'b1);
    fwd(32'h01000000, 1'b0);
    cfg_wr(8'h20, 4'hC, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h00F0FFF0, 1'b1);
    cfg_wr(8'h20, 4'h3, 32'hFFFFFFFF);
    cfg_wr(8'h24, 4'h0, 32'h0);
    rd_chk(8'h24, 32'h0, 1'b0);
    rd_chk(8'h20, 32'hFFF0FFF0, 1'b1);
  endtask
  task automatic t_set_wins;
    // System error pulse lands on the same edge as its clear
    @(posedge i_clk);
    kind <= 3'h3;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    wr <= 1'b1;
    addr <= 8'h1C;
    be_n <= 4'h0;
    wdata <= 32'h40000000;
    @(posedge i_clk);
    wr <= 1'b0;
    rd_chk(8'h1C, ST_BASE | 32'h40000000, 1'b1);
    cfg_wr(8'h1C, 4'h0, 32'h40000000);
    rd_chk(8'h1C, ST_BASE, 1'b1);
  endtask
  task automatic t_rereset;
    fire(3'h1, 1'b0, 1'b0);
    cfg_wr(8'h20, 4'h0, 32'h12301230);
    rd_chk(8'h20, 32'h12301230, 1'b1);
    rd_chk(8'h1C, ST_BASE | 32'h10000000, 1'b1);
    @(posedge i_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    arst_n <= 1'b1;
    rd_chk(8'h1C, ST_BASE, 1'b1);
    rd_chk(8'h20, 32'h0, 1'b1);
    check(lo, 32'h0);
    check(hi, 32'h000FFFFF);
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    arst_n <= 1'b1;
    t_reset();
    t_flags();
    t_window();
    t_set_wins();
    t_rereset();
    wrap_up();
  end
  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    wrap_up();
  end
endmodule
